/* pkg/fws_pkg.sv */
package fws_pkg;

  // status bit positions on the data lines
  localparam int POS_POLL     = 7;
  localparam int POS_OPTOG    = 6;
  localparam int POS_TIMEOUT  = 5;
  localparam int POS_WINDOW   = 3;
  localparam int POS_SECTOG   = 2;

  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_WDATA  = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_RDATA  = 8'h10;

  // control register fields
  localparam int CTRL_CMD_LSB = 0;   // 2-bit command
  localparam int CTRL_GO      = 4;

  // commands
  localparam logic [1:0] CMD_READ  = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_POLL  = 2'h2;
  localparam logic [1:0] CMD_WIN   = 2'h3;

  // status register fields
  localparam int ST_BUSY     = 0;
  localparam int ST_DONE_OK  = 1;
  localparam int ST_FAIL     = 2;
  localparam int ST_WINDOW   = 3;
  localparam int ST_RB       = 4;
  localparam int ST_SECTOR   = 5;

  localparam logic [15:0] RESET_DATA = 16'h00F0;

  // strobe timing
  localparam int T_STROBE_NS  = 60;
  localparam int CLK_PERIOD_NS = 5;
  localparam logic [4:0] STROBE_CYC =
    5'((T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [22:0] addr;
  } fws_strobe_t;

endpackage : fws_pkg

/* verilog/fws_host.sv */
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
// Behaviour
// [RQ1] status valid after last write strobe
// [RQ2] sector toggle alternates on selected-sector reads
// [RQ3] combine device toggle with sector toggle
// [RQ4] programming status bits and busy low
// [RQ5] erasing status bits and busy low
// [RQ6] suspended sector reads: steady six, bit two
// [RQ7] other sectors read array in suspend
// [RQ8] host reads status at valid address
// [RQ9] two consecutive reads, compare toggle bit
// [RQ10] timeout high: retest, toggling means reset
// [RQ11] restart polling from first paired read
// [RQ12] timeout flag set on pulse limit
// [RQ13] zero cannot become one except erase
// [RQ14] host issues reset after timeout failure
// [RQ15] window flag low, high after expiry
// [RQ16] fast added erases may skip window
// [RQ17] window high ignores all but suspend; the flash model drops all but reset
// [RQ18] check window before and after erase
// [RQ19] operation toggle inverts on every read
// [RQ20] ready/busy low while busy
// [RQ21] status via ordinary read cycles
module fws_host
  import fws_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output fws_strobe_t      flash_bus,
  input  wire logic [15:0] dq_in,
  output logic      [15:0] dq_out,
  output logic             dq_oe_n,
  input  wire logic        ready_busy_n
);

  typedef enum logic [5:0] {
    S_IDLE  = 6'b000001,
    S_SETUP = 6'b000010,
    S_PULSE = 6'b000100,
    S_GAP   = 6'b001000,
    S_EVAL  = 6'b010000,
    S_DONE  = 6'b100000
  } fws_state_t;

  typedef enum logic [1:0] {
    P_FIRST  = 2'h0,
    P_SECOND = 2'h1,
    P_RETEST = 2'h2
  } fws_phase_t;

  fws_state_t  state, next_state;
  fws_phase_t  phase, next_phase;
  logic [1:0]  cmd, next_cmd;
  logic [22:0] addr, next_addr;
  logic [15:0] wdata, next_wdata;
  logic [15:0] rdata, next_rdata;
  logic [15:0] prev, next_prev;
  logic [4:0]  cnt, next_cnt;
  logic        busy, next_busy;
  logic        ok, next_ok;
  logic        fail, next_fail;
  logic        window, next_window;
  logic        sector, next_sector;
  logic        is_read, next_is_read;
  logic [2:0]  rb_sync;
  logic        rb_level, next_rb_level;
  fws_strobe_t next_bus;
  logic [15:0] next_dq_out;
  logic        next_dq_oe_n;

  logic wr_acc;
  assign wr_acc  = psel & penable & pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  function automatic logic toggled(input logic [15:0] a,
                                   input logic [15:0] b,
                                   input int          pos);
    toggled = a[pos] ^ b[pos];
  endfunction : toggled

  always_comb begin
    prdata = 32'h0;
    case (paddr)
      OFS_CTRL:   prdata = {30'h0, cmd};
      OFS_ADDR:   prdata = {9'h0, addr};
      OFS_WDATA:  prdata = {16'h0, wdata};
      OFS_STATUS: prdata = {26'h0, sector, rb_level, window, fail, ok,
                            busy};
      OFS_RDATA:  prdata = {16'h0, rdata};
      default:    prdata = 32'h0;
    endcase
  end

  always_comb begin
    next_state   = state;
    next_phase   = phase;
    next_cmd     = cmd;
    next_addr    = addr;
    next_wdata   = wdata;
    next_rdata   = rdata;
    next_prev    = prev;
    next_cnt     = cnt;
    next_busy    = busy;
    next_ok      = ok;
    next_fail    = fail;
    next_window  = window;
    next_sector  = sector;
    next_is_read = is_read;
    next_bus     = flash_bus;
    next_dq_out  = dq_out;
    next_dq_oe_n = dq_oe_n;
    // three-stage sampling: change counts once stages two and three agree
    next_rb_level = (rb_sync[1] == rb_sync[2]) ? rb_sync[2] : rb_level;
    if (wr_acc && state == S_IDLE) begin
      if (paddr == OFS_ADDR) next_addr = pwdata[22:0];
      if (paddr == OFS_WDATA) next_wdata = pwdata[15:0];
    end
    case (state)
      S_IDLE: begin
        if (wr_acc && paddr == OFS_CTRL && pwdata[CTRL_GO]) begin
          next_cmd   = pwdata[CTRL_CMD_LSB +: 2];
          next_busy  = 1'b1;
          next_ok    = 1'b0;
          next_fail  = 1'b0;
          next_phase = P_FIRST;
          next_state = S_SETUP;
        end
      end
      S_SETUP: begin
        // RQ8 caller loads the program or erasing-sector address
        next_is_read   = (cmd != CMD_WRITE);
        next_bus.addr  = addr; // [RQ8]
        next_bus.ce_n  = 1'b0;
        next_bus.oe_n  = (cmd == CMD_WRITE);
        next_bus.we_n  = (cmd != CMD_WRITE);
        next_dq_oe_n   = (cmd != CMD_WRITE);
        next_dq_out    = (cmd == CMD_WRITE) ? wdata : RESET_DATA;
        next_cnt       = STROBE_CYC;
        next_state     = S_PULSE;
      end
      S_PULSE: begin
        if (cnt == 5'h0) begin
          // ordinary read cycle, oe closes it and latches the word
          if (is_read) next_rdata = dq_in; // [RQ21] [RQ19]
          next_bus.ce_n = 1'b1;
          next_bus.oe_n = 1'b1;
          next_bus.we_n = 1'b1; // [RQ1]
          next_dq_oe_n  = 1'b1;
          next_cnt      = STROBE_CYC;
          next_state    = S_GAP;
        end else begin
          next_cnt = cnt - 5'h1;
        end
      end
      S_GAP: begin
        if (cnt == 5'h0) next_state = S_EVAL;
        else next_cnt = cnt - 5'h1;
      end
      S_EVAL: begin
        next_state = S_DONE;
        if (cmd == CMD_POLL) begin
          // [RQ9] [RQ3] [RQ2]
          case (phase)
            P_FIRST: begin
              next_prev  = rdata;
              next_phase = P_SECOND;
              next_state = S_SETUP;
            end
            P_SECOND, P_RETEST: begin
              next_sector = toggled(prev, rdata, POS_SECTOG);
              next_prev   = rdata;
              if (!toggled(prev, rdata, POS_OPTOG)) begin
                next_ok = 1'b1;
              end else if (phase == P_RETEST) begin
                next_fail = 1'b1; // [RQ10] [RQ12]
                next_cmd  = CMD_WRITE;
                next_wdata = RESET_DATA; // [RQ14]
                next_state = S_SETUP;
              end else if (rdata[POS_TIMEOUT]) begin
                next_phase = P_RETEST; // [RQ10]
                next_state = S_SETUP;
              end else begin
                // still running, read once more and compare with the last word
                next_phase = P_SECOND;
                next_state = S_SETUP;
              end
            end
            default: next_phase = P_FIRST;
          endcase
        end else if (cmd == CMD_WIN) begin
          next_window = rdata[POS_WINDOW]; // [RQ15] [RQ18] [RQ17] [RQ16]
          next_ok     = 1'b1;
        end else begin
          // the recovery write after a failed poll must not report success
          next_ok = ~fail;
        end
      end
      S_DONE: begin
        // next poll command starts from the first read again
        next_busy  = 1'b0; // [RQ11]
        next_phase = P_FIRST;
        next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state     <= S_IDLE;
      phase     <= P_FIRST;
      cmd       <= CMD_READ;
      addr      <= 23'h0;
      wdata     <= 16'h0;
      rdata     <= 16'h0;
      prev      <= 16'h0;
      cnt       <= 5'h0;
      busy      <= 1'b0;
      ok        <= 1'b0;
      fail      <= 1'b0;
      window    <= 1'b0;
      sector    <= 1'b0;
      is_read   <= 1'b0;
      rb_sync   <= 3'h7;
      rb_level  <= 1'b1;
      flash_bus <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 23'h0};
      dq_out    <= 16'h0;
      dq_oe_n   <= 1'b1;
    end else begin
      state     <= next_state;
      phase     <= next_phase;
      cmd       <= next_cmd;
      addr      <= next_addr;
      wdata     <= next_wdata;
      rdata     <= next_rdata;
      prev      <= next_prev;
      cnt       <= next_cnt;
      busy      <= next_busy;
      ok        <= next_ok;
      fail      <= next_fail;
      window    <= next_window;
      sector    <= next_sector;
      is_read   <= next_is_read;
      rb_sync   <= {rb_sync[1:0], ready_busy_n}; // [RQ20]
      rb_level  <= next_rb_level;
      flash_bus <= next_bus;
      dq_out    <= next_dq_out;
      dq_oe_n   <= next_dq_oe_n;
    end
  end

endmodule : fws_host

/* verification/fws_host_chk.sv */
`timescale 1ns/1ps
module fws_host_chk
  import fws_pkg::*;
(
  input wire logic   sys_clk,
  input wire logic   rst_n,
  input wire logic   pready,
  input wire logic   pslverr,
  input fws_strobe_t flash_bus,
  input wire logic   dq_oe_n
);
  wire ce_n = flash_bus.ce_n;
  wire oe_n = flash_bus.oe_n;
  wire we_n = flash_bus.we_n;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_apb_answer: assert property (pready && !pslverr)
    else $error("apb answer wrong");
  a_reset_idle: assert property (
    !$past(rst_n) |-> oe_n && we_n && dq_oe_n)
    else $error("strobes not idle after reset");
  a_read_free: assert property (!oe_n |-> dq_oe_n && we_n && !ce_n)
    else $error("read cycle malformed");
  a_write_drive: assert property (!we_n |-> !dq_oe_n && !ce_n)
    else $error("write cycle malformed");
  a_read_width: assert property ($fell(oe_n) |=> !oe_n [*8])
    else $error("read strobe too short");
  a_write_width: assert property ($fell(we_n) |=> !we_n [*8])
    else $error("write strobe too short");
  a_read_gap: assert property ($rose(oe_n) |=> oe_n [*8])
    else $error("reads not separate");
  a_addr_steady: assert property (
    !oe_n && !$past(oe_n) |-> $stable(flash_bus.addr))
    else $error("address moved in read");
endmodule : fws_host_chk
bind fws_host fws_host_chk i_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .pready(pready), .pslverr(pslverr), .flash_bus(flash_bus),
  .dq_oe_n(dq_oe_n));

/* verification/fws_flash_model.sv */
`timescale 1ns/1ps
module fws_flash_model
  import fws_pkg::*;
#(
  parameter int SECT_LSB  = 12, // sector size of the model, plain choice
  parameter int WIN_READS = 1   // reads before the erase window closes
)
(
  input  fws_strobe_t      flash_bus,
  input  wire logic [15:0] dq_out,
  input  wire logic [7:0]  busy_len,
  input  wire logic        erasing,
  output logic      [15:0] dq_in,
  output logic             ready_busy_n
);
  logic [15:0] arr = 16'hFFFF;
  logic [15:0] last = 16'h0000;
  logic [15:0] st;
  logic [7:0]  cnt = 8'h00;
  logic [7:0]  wcnt = 8'h00;
  logic [22:0] esec = 23'h0;
  logic        ers = 1'b0;
  logic        tog = 1'b0;
  logic        stog = 1'b0;
  logic        fail = 1'b0;
  logic        oe_arm = 1'b0;
  logic        we_arm = 1'b0;
  wire         busy = (cnt != 8'h00) || fail;
  wire         win = (wcnt == 8'h00);
  wire         in_sec = ((flash_bus.addr >> SECT_LSB) == esec);
  always_comb begin
    st = arr;
    if (busy) begin
      st = 16'h0000;
      st[POS_POLL] = ers ? 1'b0 : ~arr[POS_POLL];
      st[POS_OPTOG] = tog;
      st[POS_TIMEOUT] = fail;
      st[POS_WINDOW] = ers & win;
      st[POS_SECTOG] = ers & stog;
    end
  end
  // released lines must not echo the last word
  assign dq_in = flash_bus.oe_n ? ~last : st;
  assign ready_busy_n = ~busy;
  // only a strobe seen low ends a cycle, not the first value at reset
  always @(negedge flash_bus.oe_n) oe_arm = 1'b1;
  always @(negedge flash_bus.we_n) we_arm = 1'b1;
  always @(posedge flash_bus.oe_n) begin
    if (oe_arm) begin
      oe_arm = 1'b0;
      last = st;
      if (busy) tog = ~tog;
      if (busy && ers && in_sec) stog = ~stog;
      if (wcnt != 8'h00) wcnt = wcnt - 8'h01;
      if (cnt != 8'h00) cnt = cnt - 8'h01;
    end
  end
  always @(posedge flash_bus.we_n) begin
    if (we_arm) begin
      we_arm = 1'b0;
      if (dq_out == RESET_DATA) begin
        cnt = 8'h00;
        fail = 1'b0;
      end else if (ers && busy && win) begin
        // window closed: every further command except reset is dropped
      end else if (erasing) begin
        ers = 1'b1;
        arr = 16'hFFFF;
        cnt = busy_len;
        wcnt = 8'(WIN_READS);
        esec = flash_bus.addr >> SECT_LSB;
      end else if ((dq_out & ~arr) != 16'h0000) fail = 1'b1;
      else begin
        ers = 1'b0;
        arr = dq_out;
        cnt = busy_len;
      end
    end
  end
endmodule : fws_flash_model

/* verification/fws_host_tb_top.sv */
`timescale 1ns/1ps
module fws_host_tb_top;
  import fws_pkg::*;
  logic        sys_clk, rst_n, psel, penable, pwrite, erasing;
  logic        pready, pslverr, dq_oe_n, ready_busy_n;
  logic [7:0]  paddr, busy_len;
  logic [31:0] pwdata, prdata, q, q1;
  logic [15:0] dq_in, dq_out;
  fws_strobe_t flash_bus;
  int          fails = 0, num_checks = 0;
  // word, busy reads, poll outcome, word read back
  logic [15:0] r_dat [4] = '{16'hF7EF, 16'hA5C3, 16'h2401, 16'hFFFF};
  logic [7:0]  r_len [4] = '{8'h02, 8'h00, 8'h05, 8'h03};
  logic [31:0] r_st  [4] = '{32'h12, 32'h12, 32'h12, 32'h14};
  logic [15:0] r_rd  [4] = '{16'hF7EF, 16'hA5C3, 16'h2401, 16'h2401};
  fws_host i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_bus(flash_bus), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .ready_busy_n(ready_busy_n));
  fws_flash_model i_flash (.flash_bus(flash_bus), .dq_out(dq_out),
    .busy_len(busy_len), .erasing(erasing), .dq_in(dq_in),
    .ready_busy_n(ready_busy_n));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic final_report;
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50) begin
      fails++;
      final_report;
    end
  endtask : apb
  task automatic run(input logic [1:0] c, input logic w);
    int n;
    apb(1'b1, OFS_CTRL, (32'h1 << CTRL_GO) | {30'h0, c});
    while (w && n < 4000) begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
      if (q[ST_BUSY] === 1'b0) break;
    end
    if (n == 4000) begin
      fails++;
      final_report;
    end
  endtask : run
  initial begin
    {rst_n, psel, penable, pwrite, erasing} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    busy_len = 8'h00;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    apb(1'b0, OFS_STATUS, 32'h0);
    check(q & 32'h3F, 32'h10);
    apb(1'b0, 8'h14, 32'h0);
    check(q, 32'h0);
    $display("reset and unmapped done");
    for (int i = 0; i < 4; i++) begin
      busy_len <= r_len[i];
      apb(1'b1, OFS_ADDR, 32'h0000_0100);
      apb(1'b1, OFS_WDATA, {16'h0, r_dat[i]});
      run(CMD_WRITE, 1'b1);
      run(CMD_POLL, 1'b1);
      apb(1'b0, OFS_STATUS, 32'h0);
      check(q & 32'h1F, r_st[i]);
      run(CMD_READ, 1'b1);
      apb(1'b0, OFS_RDATA, 32'h0);
      check(q, {16'h0, r_rd[i]});
      $display("row %0d done", i);
    end
    // erase: window opens then closes, late command dropped
    erasing <= 1'b1;
    busy_len <= 8'h08;
    apb(1'b1, OFS_WDATA, 32'h0000_0030);
    run(CMD_WRITE, 1'b1);
    check(q & 32'h1F, 32'h02);
    run(CMD_WIN, 1'b1);
    check(q & 32'h1F, 32'h02);
    run(CMD_WIN, 1'b1);
    check(q & 32'h1F, 32'h0A);
    run(CMD_WRITE, 1'b1);
    run(CMD_WIN, 1'b1);
    check(q & 32'h1F, 32'h0A);
    run(CMD_READ, 1'b1);
    apb(1'b0, OFS_RDATA, 32'h0);
    q1 = q;
    check(q1 & 32'hA8, 32'h08);
    run(CMD_READ, 1'b1);
    apb(1'b0, OFS_RDATA, 32'h0);
    check((q1 ^ q) & 32'h44, 32'h44);
    run(CMD_POLL, 1'b1);
    check(q & 32'h1F, 32'h1A);
    run(CMD_READ, 1'b1);
    apb(1'b0, OFS_RDATA, 32'h0);
    check(q, 32'h0000_FFFF);
    erasing <= 1'b0;
    $display("erase done");
    // reset lands in the middle of a long poll
    busy_len <= 8'h64;
    apb(1'b1, OFS_WDATA, 32'h0000_0001);
    run(CMD_WRITE, 1'b1);
    run(CMD_POLL, 1'b0);
    repeat (40) @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    check({29'h0, flash_bus.ce_n, flash_bus.oe_n, flash_bus.we_n},
          32'h7);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(q & 32'h7, 32'h0);
    $display("mid reset done");
    final_report;
  end
endmodule : fws_host_tb_top
